// file: pkg/scrambler_pkg.sv
// Constants and carriers for the data field scrambler.
// Assumes a single byte-rate clock domain.
package scrambler_pkg;
    localparam int LFSR_W      = 15;
    localparam int BYTE_W      = 8;
    localparam int FIELD_LEN   = 9424;
    localparam int CNT_W       = 14;
    localparam int FIFO_DEPTH  = 8;
    localparam logic [LFSR_W-1:0] TAP_MASK_DEFAULT = 15'h0003;
    localparam logic [LFSR_W-1:0] LFSR_RESET = 15'h0001;
    localparam logic [CNT_W-1:0]  CNT_RESET  = 14'h0000;

    // Byte kinds carried beside the data
    typedef enum logic [1:0] {
        KIND_DATA,
        KIND_RESYNC,
        KIND_REFERENCE,
        KIND_LOCK
    } byte_kind_e;

    typedef struct packed {
        logic [7:0] data;
        byte_kind_e kind;
        logic       first;
    } stream_beat_s;
endpackage

// file: rtl/beat_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes same clock and reset as its user.
`timescale 1ns/1ps
module beat_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             en_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_s;

    fifo_state_s s_q;
    fifo_state_s s_d;
    logic        push;
    logic        pop;

    assign in_ready_o  = (s_q.cnt != DEPTH[AW:0]);
    assign out_valid_o = (s_q.cnt != '0);
    assign out_data_o  = s_q.mem[s_q.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else if (en_i) begin
            s_q <= s_d;
        end
    end
endmodule

// file: rtl/data_field_scrambler.sv
// Data field scrambler/descrambler with preset per sector.
// Assumes upstream marks the first byte of each field and tags inserted bytes.
// Operation
// R1: Only data bytes are XORed; resync, reference and lock bytes pass unchanged.
// R2: On encode the block sits after check-byte generation and before pattern insertion.
// R3: On decode the same block sits after pattern removal and before ECC checking.
// R4: A 15-stage register supplies its low 8 stages as the scrambling byte per 8-bit shift.
// R5: At each field start the register is preset from the block number's low nibble.
// R6: The preset table is the sixteen listed hex values indexed by that nibble.
// R7: Successive sectors get successive presets, repeating every 16 sectors.
// R8: The first scrambling byte is the preset's low byte without shifting.
// R9: Each later scrambled byte uses the register after eight more shifts.
// R10: Output equals input XOR scrambling byte, identical in both directions.
// R11: Bytes are handled in recording order across the 9424-byte sequence.
// R12: Feedback taps are a parameter mask.
`timescale 1ns/1ps
module data_field_scrambler #(
    parameter logic [14:0] TAP_MASK   = scrambler_pkg::TAP_MASK_DEFAULT,
    parameter int          FIFO_DEPTH = scrambler_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        en_i,
    input  wire logic [3:0]  physical_block_number_i,
    input  wire logic [7:0]  in_data_i,
    input  wire logic [1:0]  in_kind_i,
    input  wire logic        in_first_i,
    input  wire logic        in_valid_i,
    output logic             in_ready_o,
    output logic [7:0]       out_data_o,
    output logic [1:0]       out_kind_o,
    output logic             out_first_o,
    output logic             out_valid_o,
    input  wire logic        out_ready_i,
    output logic [13:0]      byte_index_o
);
    localparam int SW = $bits(scrambler_pkg::stream_beat_s);
    localparam int OW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        logic [14:0]                 lfsr;
        logic [13:0]                 cnt;
        scrambler_pkg::stream_beat_s out;
        logic                        valid;
        logic [OW-1:0]               occ;
        logic                        rdy;
    } scr_state_s;

    scr_state_s                  s_q;
    scr_state_s                  s_d;
    scrambler_pkg::stream_beat_s fifo_in;
    scrambler_pkg::stream_beat_s head;
    logic [SW-1:0]               head_bits;
    logic                        head_valid;
    logic                        head_ready;
    logic                        fifo_ready;
    logic                        push;
    logic                        pop;
    logic                        drain;
    logic [14:0]                 seed;
    logic [14:0]                 stage [9];
    logic [7:0]                  feed;

    function automatic logic [14:0] preset(input logic [3:0] nib);
        unique case (nib)
            4'h0: preset = 15'h0001;
            4'h1: preset = 15'h5500;
            4'h2: preset = 15'h0002;
            4'h3: preset = 15'h2A00;
            4'h4: preset = 15'h0004;
            4'h5: preset = 15'h5400;
            4'h6: preset = 15'h0008;
            4'h7: preset = 15'h2800;
            4'h8: preset = 15'h0010;
            4'h9: preset = 15'h5000;
            4'hA: preset = 15'h0020;
            4'hB: preset = 15'h2001;
            4'hC: preset = 15'h0040;
            4'hD: preset = 15'h4002;
            4'hE: preset = 15'h0080;
            4'hF: preset = 15'h0005;
        endcase
    endfunction

    // Only field data is whitened; inserted patterns must stay recognisable
    function automatic logic is_scrambled(input scrambler_pkg::byte_kind_e kind);
        is_scrambled = (kind == scrambler_pkg::KIND_DATA); // R1
    endfunction

    assign fifo_in = '{
        data:  in_data_i,
        kind:  scrambler_pkg::byte_kind_e'(in_kind_i),
        first: in_first_i
    };

    // FIFO decouples upstream from downstream stalls
    beat_fifo #(
        .WIDTH (SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .en_i        (en_i),
        .in_data_i   (fifo_in),
        .in_valid_i  (in_valid_i),
        .in_ready_o  (fifo_ready),
        .out_data_o  (head_bits),
        .out_valid_o (head_valid),
        .out_ready_i (head_ready)
    );

    assign head       = scrambler_pkg::stream_beat_s'(head_bits);
    assign head_ready = !s_q.valid || out_ready_i;
    assign push       = in_valid_i && fifo_ready;
    assign pop        = head_valid && head_ready;
    assign drain      = s_q.valid && out_ready_i;
    assign seed       = preset(physical_block_number_i); // R5 R6 R7

    // Eight one-bit steps per byte; left shift with parity feedback into r0
    assign stage[0] = s_q.lfsr;
    for (genvar g = 0; g < 8; g++) begin : g_step
        assign feed[g]      = ^(stage[g] & TAP_MASK); // R12
        assign stage[g + 1] = {stage[g][13:0], feed[g]}; // R4
    end

    always_comb begin
        s_d = s_q;
        if (drain) begin
            s_d.valid = 1'b0;
        end
        if (pop) begin
            s_d.valid = 1'b1;
            s_d.out   = head; // R1 R2 R3
            if (is_scrambled(head.kind)) begin
                if (head.first) begin
                    s_d.lfsr = seed; // R8
                    s_d.cnt  = 14'h0001;
                end else begin
                    s_d.lfsr = stage[8]; // R9
                    s_d.cnt  = s_q.cnt + 14'h0001; // R11
                end
                s_d.out.data = head.data ^ s_d.lfsr[7:0]; // R10
            end
        end
        // Mirror of the queue fill so ready leaves from a register
        s_d.occ = s_q.occ + OW'(push) - OW'(pop);
        s_d.rdy = (s_d.occ != OW'(FIFO_DEPTH)); // R11
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.lfsr  <= scrambler_pkg::LFSR_RESET;
            s_q.cnt   <= scrambler_pkg::CNT_RESET;
            s_q.out   <= '0;
            s_q.valid <= 1'b0;
            s_q.occ   <= '0;
            s_q.rdy   <= 1'b1;
        end else if (en_i) begin
            s_q <= s_d;
        end
    end

    assign in_ready_o   = s_q.rdy;
    assign out_data_o   = s_q.out.data;
    assign out_kind_o   = s_q.out.kind;
    assign out_first_o  = s_q.out.first;
    assign out_valid_o  = s_q.valid;
    assign byte_index_o = s_q.cnt;
endmodule

// file: testbench/scrambler_monitor.sv
// Port checker for the data field scrambler.
// Assumes one clock; beats in flight counted from handshakes.
`timescale 1ns/1ps
module scrambler_monitor (
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       en_i,
    input wire logic       in_valid_i,
    input wire logic       in_ready_o,
    input wire logic [7:0] out_data_o,
    input wire logic [1:0] out_kind_o,
    input wire logic       out_first_o,
    input wire logic       out_valid_o,
    input wire logic       out_ready_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [4:0] occ_q;
    logic       take;
    logic       give;
    assign take = en_i && in_valid_i && in_ready_o;
    assign give = en_i && out_valid_o && out_ready_i;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            occ_q <= 5'h00;
        end else begin
            occ_q <= occ_q + 5'(take) - 5'(give);
        end
    end
    sequence s_take_empty; take && occ_q == 5'h00; endsequence
    property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o); endproperty
    property p_first; out_valid_o && out_first_o |-> out_kind_o == 2'h0; endproperty
    property p_full; !in_ready_o |-> occ_q >= 5'h08; endproperty
    property p_cap; occ_q <= 5'h09; endproperty
    property p_idle; occ_q == 5'h00 |-> !out_valid_o; endproperty
    property p_early; s_take_empty |=> !out_valid_o; endproperty
    property p_answer; s_take_empty ##1 en_i |=> out_valid_o; endproperty
    property p_freeze; !en_i && out_valid_o |=> out_valid_o && $stable(out_data_o); endproperty
    a_hold: assert property (p_hold) else $error("output beat changed under stall");
    a_first: assert property (p_first) else $error("field start on a non-data byte");
    a_full: assert property (p_full) else $error("input refused below capacity");
    a_cap: assert property (p_cap) else $error("more beats held than capacity");
    a_idle: assert property (p_idle) else $error("output beat with nothing taken");
    a_early: assert property (p_early) else $error("answer one cycle after take");
    a_answer: assert property (p_answer) else $error("answer missing two cycles after take");
    a_freeze: assert property (p_freeze) else $error("output moved while disabled");
endmodule
bind data_field_scrambler scrambler_monitor i_scrambler_monitor (.clk_sys_i, .rst_n_i, .en_i, .in_valid_i,
    .in_ready_o, .out_data_o, .out_kind_o, .out_first_o, .out_valid_o, .out_ready_i);

// file: testbench/byte_sink.sv
// Downstream stand-in for the modulation encoder.
// Assumes the bench selects stalled, slow or prompt acceptance.
`timescale 1ns/1ps
module byte_sink (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic stall_i,
    input  wire logic slow_i,
    output logic      ready_o
);
    logic tick_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= !tick_q;
        end
    end
    // Slow mode accepts every other cycle
    assign ready_o = !stall_i && (!slow_i || tick_q);
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the data field scrambler.
// Assumes a 200 MHz clock and the byte sink downstream.
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, en_i = 1'b1, in_valid_i = 1'b0, in_first_i = 1'b0;
    logic        in_ready_o, out_first_o, out_valid_o, out_ready_i, stall = 1'b0, slow = 1'b0;
    logic [3:0]  pbn = 4'h0;
    logic [7:0]  in_data_i = 8'h00, out_data_o;
    logic [1:0]  in_kind_i = 2'h0, out_kind_o;
    logic [13:0] byte_index_o;
    logic [14:0] r = 15'h0000;
    logic [10:0] exp_q[$], got_q[$];
    int          num_errors = 0, n_tests = 0, cur_n = 0, exp_idx = 0;
    logic [14:0] preset [16] = '{15'h0001, 15'h5500, 15'h0002, 15'h2A00, 15'h0004, 15'h5400, 15'h0008,
        15'h2800, 15'h0010, 15'h5000, 15'h0020, 15'h2001, 15'h0040, 15'h4002, 15'h0080, 15'h0005};
    initial forever #2.5 clk_sys_i = !clk_sys_i;
    data_field_scrambler i_data_field_scrambler (.clk_sys_i, .rst_n_i, .en_i, .physical_block_number_i(pbn),
        .in_data_i, .in_kind_i, .in_first_i, .in_valid_i, .in_ready_o, .out_data_o, .out_kind_o, .out_first_o,
        .out_valid_o, .out_ready_i, .byte_index_o);
    byte_sink i_byte_sink (.clk_sys_i, .rst_n_i, .stall_i(stall), .slow_i(slow), .ready_o(out_ready_i));
    always @(posedge clk_sys_i) begin
        if (en_i && out_valid_o && out_ready_i) begin
            got_q.push_back({out_first_o, out_data_o, out_kind_o});
        end
    end
    function automatic logic [14:0] nxt(input logic [14:0] v);
        for (int i = 0; i < 8; i++) v = {v[13:0], ^(v & scrambler_pkg::TAP_MASK_DEFAULT)};
        return v;
    endfunction
    task automatic send(input logic [7:0] d, input logic [1:0] k, input logic f);
        @(negedge clk_sys_i);
        pbn = 4'(cur_n);
        in_data_i = d;
        in_kind_i = k;
        in_first_i = f;
        in_valid_i = 1'b1;
        r = f ? preset[pbn] : (k == 2'h0 ? nxt(r) : r);
        exp_q.push_back({f, (k == 2'h0 ? d ^ r[7:0] : d), k});
        if (k == 2'h0) exp_idx = f ? 1 : exp_idx + 1;
        do @(posedge clk_sys_i); while (!(in_ready_o && en_i));
    endtask
    task automatic check_index();
        n_tests++;
        if (byte_index_o !== 14'(exp_idx)) begin
            num_errors++;
            $display("CHECK FAILED byte_index_o expected %0d seen %0d", exp_idx, byte_index_o);
        end
    endtask
    task automatic drain_check();
        @(negedge clk_sys_i);
        in_valid_i = 1'b0;
        for (int i = 0; i < 200 && got_q.size() < exp_q.size(); i++) @(negedge clk_sys_i);
        while (exp_q.size() > 0) begin
            n_tests++;
            if (got_q.size() == 0 || got_q[0] !== exp_q[0]) begin
                num_errors++;
                $display("CHECK FAILED beat expected %h seen %h", exp_q[0], got_q.size() ? got_q[0] : 11'h7FF);
            end
            void'(exp_q.pop_front());
            if (got_q.size() > 0) void'(got_q.pop_front());
        end
        n_tests++;
        if (got_q.size() != 0) begin
            num_errors++;
            $display("CHECK FAILED extra beats expected 0 seen %0d", got_q.size());
            got_q.delete();
        end
        check_index();
    endtask
    task automatic t_reset();
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        exp_idx = 0;
        @(negedge clk_sys_i);
        n_tests++;
        if (in_ready_o !== 1'b1 || out_valid_o !== 1'b0 || byte_index_o !== 14'h0000) begin
            num_errors++;
            $display("CHECK FAILED reset state expected 1 0 0 seen %b %b %0d", in_ready_o, out_valid_o, byte_index_o);
        end
        rst_n_i = 1'b1;
        cur_n = 15;
        send(8'hA5, 2'h0, 1'b1);
        send(8'h3C, 2'h3, 1'b0);
        send(8'h96, 2'h0, 1'b0);
        drain_check();
    endtask
    task automatic t_fields();
        // Prompt sink so each block number is sampled before the next one is set
        for (int n = 0; n < 17; n++) begin
            cur_n = n % 16;
            send(8'(n), 2'h0, 1'b1);
            for (int k = 1; k < 4; k++) send(8'hC3, 2'(k), 1'b0);
            send(8'hFF, 2'h0, 1'b0);
            send(8'h00, 2'h0, 1'b0);
        end
        drain_check();
    endtask
    task automatic t_full();
        cur_n = 9;
        stall = 1'b1;
        send(8'h5A, 2'h0, 1'b1);
        for (int i = 0; i < 8; i++) send(8'(i * 37), 2'h0, 1'b0);
        @(negedge clk_sys_i);
        in_valid_i = 1'b0;
        en_i = 1'b0;
        n_tests++;
        if (in_ready_o !== 1'b0) begin
            num_errors++;
            $display("CHECK FAILED in_ready_o expected 0 seen %b", in_ready_o);
        end
        @(negedge clk_sys_i);
        en_i = 1'b1;
        stall = 1'b0;
        slow = 1'b1;
        drain_check();
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_fields();
        t_full();
        t_reset();
        give_verdict();
    end
    initial begin
        #50000;
        num_errors++;
        give_verdict();
    end
endmodule
